// ### core/logic_error_defs.svh
/*
   Constants of the logic engine error reporter: register offsets, field positions,
   reset values and error codes. Assumes inclusion by bare name from core/.
*/
`ifndef LOGIC_ERROR_DEFS_SVH
`define LOGIC_ERROR_DEFS_SVH

// ----------------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------------
`define OFS_CONTROL 5'h00
`define OFS_EVENT 5'h04
`define OFS_STATUS 5'h08
`define OFS_OPERAND 5'h0C
`define OFS_RESULT 5'h10
`define OFS_ARITH_HI 5'h14
`define OFS_ARITH_LO 5'h18
`define OFS_DIVISOR 5'h1C

// ----------------------------------------------------------------------------
// Field positions and reset values
// ----------------------------------------------------------------------------
`define CTL_ENABLE_BIT 0
`define CTL_RUN_BIT 1
`define CTL_ERRCLR_BIT 2
`define CTL_SWEEP_BIT 3
`define CTL_OVFWR_BIT 4
`define CTL_OVFVAL_BIT 5
`define CTL_RESET 32'h0000_0000
`define AQ_MIN_RESET 32'h0000_0000
`define AQ_MAX_RESET 32'h0000_2710

// ----------------------------------------------------------------------------
// Error codes
// ----------------------------------------------------------------------------
`define ERR_DOUT_CFG 16'h000A
`define ERR_CTLBIT_CFG 16'h000B
`define ERR_PRE_BASE 16'hF0A0
`define ERR_HALT 16'h0091
`define ERR_TIME_LIMIT 16'h0092
`define ERR_DIV_ZERO 16'h0093
`define ERR_DIV_OVF 16'h0094
`define ERR_ADD_OVF 16'h0095
`define ERR_ABS_OVF 16'h0096
`define ERR_TIME_WARN 16'h0097
`define ERR_FIRST_SWEEP 16'h0098
`define ERR_BAD_PROGRAM 16'h0099
`define ERR_LOGIC_STOP 16'h009A
`define ERR_AQ_RANGE 16'h009B

`endif

// ### core/logic_error_pkg.sv
/*
   Types of the logic engine error reporter.
   Assumes nothing of its surroundings.
*/
package logic_error_pkg;
   typedef enum logic [1:0] {
      AXI_IDLE = 2'b00,
      AXI_RESP = 2'b01
   } bus_state_t;

   typedef enum logic [3:0] {
      EV_NONE = 4'h0, EV_DOUT_CFG = 4'h1, EV_CTLBIT_CFG = 4'h2, EV_PREPROC = 4'h3,
      EV_HALT = 4'h4, EV_TIME_LIMIT = 4'h5, EV_TIME_WARN = 4'h6, EV_FIRST_SWEEP = 4'h7,
      EV_BAD_PROGRAM = 4'h8, EV_LOGIC_STOP = 4'h9
   } event_t;

   typedef enum logic [1:0] {
      OP_ADD = 2'h0, OP_SUB = 2'h1, OP_ABS = 2'h2, OP_DIV = 2'h3
   } arith_op_t;
endpackage

// ### core/operand_loader.sv
/*
   Operand loader: keeps the low bits of a value that fit a destination width and
   sign-extends or zero-extends narrow operands to 32 bits.
   Assumes widths 1 to 32, given in a 6-bit field on the same clock.
*/
`timescale 1ns/10ps
module operand_loader #(
   parameter int DataWidth = 32
) (
   input wire logic [DataWidth-1:0] rawValue,
   input wire logic [5:0] widthBits,
   input wire logic isSigned,
   output logic [DataWidth-1:0] loadedValue
);
   // ---------------------------------------------------------------------------
   // Truncate and extend
   // ---------------------------------------------------------------------------
   logic [DataWidth-1:0] keepMask;
   logic signBit;
   logic [5:0] width;

   always_comb begin
      width = (widthBits == 6'h00) ? 6'h01 : widthBits;
      keepMask = '0;
      signBit = 1'b0;
      for (int i = 0; i < DataWidth; i++) begin
         if (i < int'(width)) begin
            keepMask[i] = 1'b1;
         end
         if (i == int'(width) - 1) begin
            signBit = rawValue[i];
         end
      end
      // Single-bit operands are always unsigned, so they never extend.
      if (isSigned && width != 6'h01 && signBit) begin
         loadedValue = rawValue | ~keepMask;
      end else begin
         loadedValue = rawValue & keepMask;
      end
   end
endmodule // operand_loader

// ### core/logic_error_reporter.sv
/*
   Error and operand handling of the logic engine: classifies download, preprocessing
   and runtime errors, holds the module status code, checks arithmetic, and drives
   the first-sweep flag. Registers are reached over AXI4-Lite.
   Assumes one clock, a synchronous reset and a well behaved AXI4-Lite master.
*/
`timescale 1ns/10ps
`include "logic_error_defs.svh"
module logic_error_reporter
   import logic_error_pkg::*;
#(
   parameter int AxisCount = 4
) (
   input wire logic clk,
   input wire logic srst,
   input wire logic [4:0] awaddr,
   input wire logic awvalid,
   output logic awready,
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   input wire logic wvalid,
   output logic wready,
   output logic [1:0] bresp,
   output logic bvalid,
   input wire logic bready,
   input wire logic [4:0] araddr,
   input wire logic arvalid,
   output logic arready,
   output logic [31:0] rdata,
   output logic [1:0] rresp,
   output logic rvalid,
   input wire logic rready,
   input wire logic eventValid,
   input wire event_t eventKind,
   input wire logic [4:0] preprocIndex,
   input wire logic [1:0] stopAxis,
   input wire logic sweepStart,
   input wire logic haltRequest,
   input wire logic [AxisCount-1:0] axisFault,
   output logic [15:0] moduleStatusCode,
   output logic statusAxisValid,
   output logic [1:0] statusAxis,
   output logic moduleFastStop,
   output logic [AxisCount-1:0] axisFastStop,
   output logic logicHalted,
   output logic firstSweepFlag,
   output logic overflowFlag,
   output logic [31:0] analogCommandWord
);
   // ---------------------------------------------------------------------------
   // Bus slave
   // ---------------------------------------------------------------------------
   bus_state_t wrState_q;
   bus_state_t rdState_q;
   logic awHeld_q;
   logic wHeld_q;
   logic [4:0] awAddr_q;
   logic [31:0] wData_q;
   logic [3:0] wStrb_q;
   logic wrFire;
   logic [4:0] wrAddr;
   logic [31:0] wrData;
   logic [3:0] wrStrb;
   logic [31:0] rdWord;
   logic rdHit;

   assign awready = (wrState_q == AXI_IDLE) && !awHeld_q;
   assign wready = (wrState_q == AXI_IDLE) && !wHeld_q;
   assign arready = (rdState_q == AXI_IDLE);
   assign wrAddr = awHeld_q ? awAddr_q : awaddr;
   assign wrData = wHeld_q ? wData_q : wdata;
   assign wrStrb = wHeld_q ? wStrb_q : wstrb;
   assign wrFire = (wrState_q == AXI_IDLE) && (awHeld_q || awvalid) && (wHeld_q || wvalid);

   always_ff @(posedge clk) begin
      if (srst) begin
         wrState_q <= AXI_IDLE;
         awHeld_q <= 1'b0;
         wHeld_q <= 1'b0;
         awAddr_q <= '0;
         wData_q <= '0;
         wStrb_q <= '0;
         bvalid <= 1'b0;
         bresp <= 2'b00;
      end else if (wrState_q == AXI_IDLE) begin
         if (wrFire) begin
            awHeld_q <= 1'b0;
            wHeld_q <= 1'b0;
            bvalid <= 1'b1;
            bresp <= (wrAddr[1:0] == 2'b00 && wrAddr != `OFS_EVENT) ? 2'b00 : 2'b10;
            wrState_q <= AXI_RESP;
         end else begin
            if (awvalid && !awHeld_q) begin
               awHeld_q <= 1'b1;
               awAddr_q <= awaddr;
            end
            if (wvalid && !wHeld_q) begin
               wHeld_q <= 1'b1;
               wData_q <= wdata;
               wStrb_q <= wstrb;
            end
         end
      end else if (bready) begin
         bvalid <= 1'b0;
         wrState_q <= AXI_IDLE;
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         rdState_q <= AXI_IDLE;
         rvalid <= 1'b0;
         rdata <= '0;
         rresp <= 2'b00;
      end else if (rdState_q == AXI_IDLE) begin
         if (arvalid) begin
            rvalid <= 1'b1;
            rdata <= rdHit ? rdWord : 32'h0000_0000;
            rresp <= rdHit ? 2'b00 : 2'b10;
            rdState_q <= AXI_RESP;
         end
      end else if (rready) begin
         rvalid <= 1'b0;
         rdState_q <= AXI_IDLE;
      end
   end

   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nv, input logic [3:0] be);
      logic [31:0] res;
      res = old;
      for (int b = 0; b < 4; b++) begin
         if (be[b]) begin
            res[8*b +: 8] = nv[8*b +: 8];
         end
      end
      return res;
   endfunction

   // ---------------------------------------------------------------------------
   // Software registers
   // ---------------------------------------------------------------------------
   logic [31:0] control_q;
   logic [31:0] operand_q;
   logic [31:0] arithHi_q;
   logic [31:0] arithLo_q;
   logic [31:0] divisor_q;
   logic [31:0] aqMax_q;
   logic errClrPrev_q;
   logic errClrToggle;
   logic ovfWrite;
   logic arithGo;
   arith_op_t arithOp;

   always_ff @(posedge clk) begin
      if (srst) begin
         control_q <= `CTL_RESET;
         operand_q <= '0;
         arithHi_q <= '0;
         arithLo_q <= '0;
         divisor_q <= '0;
         aqMax_q <= `AQ_MAX_RESET;
      end else if (wrFire) begin
         if (wrAddr == `OFS_CONTROL) begin
            control_q <= merge(control_q, wrData, wrStrb);
         end else if (wrAddr == `OFS_OPERAND) begin
            operand_q <= merge(operand_q, wrData, wrStrb);
         end else if (wrAddr == `OFS_ARITH_HI) begin
            arithHi_q <= merge(arithHi_q, wrData, wrStrb);
         end else if (wrAddr == `OFS_ARITH_LO) begin
            arithLo_q <= merge(arithLo_q, wrData, wrStrb);
         end else if (wrAddr == `OFS_DIVISOR) begin
            divisor_q <= merge(divisor_q, wrData, wrStrb);
         end else if (wrAddr == `OFS_RESULT) begin
            aqMax_q <= merge(aqMax_q, wrData, wrStrb);
         end
      end
   end

   // Writing the operation byte (byte 3 of operand B) starts one operation.
   assign arithGo = wrFire && (wrAddr == `OFS_DIVISOR) && wrStrb[3];
   assign arithOp = arith_op_t'(wrData[31:30]);
   assign ovfWrite = wrFire && (wrAddr == `OFS_CONTROL) && wrStrb[0] && wrData[`CTL_OVFWR_BIT];

   always_ff @(posedge clk) begin
      if (srst) begin
         errClrPrev_q <= 1'b0;
      end else begin
         errClrPrev_q <= control_q[`CTL_ERRCLR_BIT];
      end
   end
   // Any edge on the error-clear bit counts, so software need not restore it.
   assign errClrToggle = errClrPrev_q != control_q[`CTL_ERRCLR_BIT];

   // ---------------------------------------------------------------------------
   // Operand load and analog command check
   // ---------------------------------------------------------------------------
   logic [31:0] loaded;
   logic aqStore_q;
   logic aqReject;

   operand_loader #(
      .DataWidth(32)
   ) u_loader (
      .rawValue(operand_q),
      .widthBits(control_q[13:8]),
      .isSigned(control_q[14]),
      .loadedValue(loaded)
   );

   assign aqReject = ($signed(loaded) < $signed(`AQ_MIN_RESET)) || ($signed(loaded) > $signed(aqMax_q));

   always_ff @(posedge clk) begin
      if (srst) begin
         analogCommandWord <= '0;
         aqStore_q <= 1'b0;
      end else begin
         aqStore_q <= wrFire && (wrAddr == `OFS_OPERAND) && wrStrb[3];
         if (control_q[15] && !aqReject) begin
            analogCommandWord <= loaded;
         end
      end
   end

   // ---------------------------------------------------------------------------
   // Arithmetic checks
   // ---------------------------------------------------------------------------
   logic signed [63:0] dividend;
   logic signed [31:0] opA;
   logic signed [31:0] opB;
   logic signed [32:0] sum;
   logic signed [63:0] quotient;
   logic addOvf;
   logic absOvf;
   logic divZero;
   logic divOvf;
   logic [31:0] result_q;

   assign dividend = {arithHi_q, arithLo_q};
   assign opA = arithLo_q;
   assign opB = divisor_q;

   always_comb begin
      sum = '0;
      quotient = '0;
      addOvf = 1'b0;
      absOvf = 1'b0;
      divZero = 1'b0;
      divOvf = 1'b0;
      case (arithOp)
         OP_ADD: begin
            sum = {opA[31], opA} + {opB[31], opB};
            addOvf = sum[32] != sum[31];
         end
         OP_SUB: begin
            sum = {opA[31], opA} - {opB[31], opB};
            addOvf = sum[32] != sum[31];
         end
         OP_ABS: begin
            sum = opA[31] ? -{opA[31], opA} : {opA[31], opA};
            absOvf = opA == 32'sh8000_0000;
         end
         default: begin
            divZero = opB == 32'sh0000_0000;
            if (!divZero) begin
               quotient = dividend / 64'(opB);
               divOvf = quotient > 64'sh0000_0000_7FFF_FFFF || quotient < -64'sh0000_0000_8000_0000;
            end
         end
      endcase
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         result_q <= '0;
      end else if (arithGo) begin
         result_q <= (arithOp == OP_DIV) ? quotient[31:0] : sum[31:0];
      end
   end

   // ---------------------------------------------------------------------------
   // First sweep and overflow flags
   // ---------------------------------------------------------------------------
   logic runArmed_q;

   always_ff @(posedge clk) begin
      if (srst) begin
         runArmed_q <= 1'b0;
         firstSweepFlag <= 1'b0;
      end else if (!control_q[`CTL_ENABLE_BIT] || !control_q[`CTL_RUN_BIT]) begin
         runArmed_q <= 1'b1;
         firstSweepFlag <= 1'b0;
      end else if (sweepStart) begin
         firstSweepFlag <= runArmed_q;
         runArmed_q <= 1'b0;
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         overflowFlag <= 1'b0;
      end else if (arithGo && (addOvf || absOvf)) begin
         overflowFlag <= 1'b1;
      end else if ((sweepStart && runArmed_q) || errClrToggle || (ovfWrite && !wrData[`CTL_OVFVAL_BIT])) begin
         overflowFlag <= 1'b0;
      end
   end

   // ---------------------------------------------------------------------------
   // Error classification and status code
   // ---------------------------------------------------------------------------
   logic [15:0] code;
   logic codeValid;
   logic stopModule;
   logic stopAxisEv;

   always_comb begin
      code = 16'h0000;
      codeValid = 1'b1;
      stopModule = 1'b0;
      stopAxisEv = 1'b0;
      if (haltRequest) begin
         code = `ERR_HALT;
         stopModule = 1'b1;
      end else if (arithGo && divZero && arithOp == OP_DIV) begin
         code = `ERR_DIV_ZERO;
         stopModule = 1'b1;
      end else if (arithGo && divOvf && arithOp == OP_DIV) begin
         code = `ERR_DIV_OVF;
         stopModule = 1'b1;
      end else if (arithGo && addOvf) begin
         code = `ERR_ADD_OVF;
      end else if (arithGo && absOvf) begin
         code = `ERR_ABS_OVF;
      end else if (eventValid) begin
         case (eventKind)
            EV_DOUT_CFG: code = `ERR_DOUT_CFG;
            EV_CTLBIT_CFG: code = `ERR_CTLBIT_CFG;
            EV_PREPROC: begin
               // Codes F0A0..F0AE and F0B0..F0B8 follow the index; F0AF is not used.
               code = `ERR_PRE_BASE + {11'h000, preprocIndex};
               codeValid = preprocIndex != 5'h0F && preprocIndex <= 5'h18;
            end
            EV_HALT: begin
               code = `ERR_HALT;
               stopModule = 1'b1;
            end
            EV_TIME_LIMIT: begin
               code = `ERR_TIME_LIMIT;
               stopModule = 1'b1;
            end
            EV_TIME_WARN: code = `ERR_TIME_WARN;
            EV_FIRST_SWEEP: code = `ERR_FIRST_SWEEP;
            EV_BAD_PROGRAM: code = `ERR_BAD_PROGRAM;
            EV_LOGIC_STOP: begin
               code = `ERR_LOGIC_STOP;
               stopAxisEv = 1'b1;
            end
            default: codeValid = 1'b0;
         endcase
      end else if (aqStore_q && aqReject && control_q[15]) begin
         code = `ERR_AQ_RANGE;
      end else begin
         codeValid = 1'b0;
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         moduleStatusCode <= '0;
         statusAxisValid <= 1'b0;
         statusAxis <= '0;
      end else if (codeValid) begin
         moduleStatusCode <= code;
         statusAxisValid <= stopAxisEv;
         statusAxis <= stopAxis;
      end else if (errClrToggle) begin
         moduleStatusCode <= '0;
         statusAxisValid <= 1'b0;
      end
   end

   // Stops latch until the host toggles error-clear; a new stop in that cycle wins.
   always_ff @(posedge clk) begin
      if (srst) begin
         moduleFastStop <= 1'b0;
         logicHalted <= 1'b0;
         axisFastStop <= '0;
      end else begin
         if (codeValid && stopModule) begin
            moduleFastStop <= 1'b1;
            logicHalted <= 1'b1;
         end else if (errClrToggle) begin
            moduleFastStop <= 1'b0;
            logicHalted <= 1'b0;
         end
         for (int a = 0; a < AxisCount; a++) begin
            if ((codeValid && stopAxisEv && int'(stopAxis) == a) || axisFault[a]) begin
               axisFastStop[a] <= 1'b1;
            end else if (errClrToggle) begin
               axisFastStop[a] <= 1'b0;
            end
         end
      end
   end

   // ---------------------------------------------------------------------------
   // Read decode
   // ---------------------------------------------------------------------------
   always_comb begin
      rdHit = 1'b1;
      if (araddr == `OFS_CONTROL) begin
         rdWord = control_q;
      end else if (araddr == `OFS_EVENT) begin
         rdWord = {24'h000000, 2'b00, logicHalted, moduleFastStop, statusAxisValid, statusAxis, overflowFlag};
      end else if (araddr == `OFS_STATUS) begin
         rdWord = {13'h0000, firstSweepFlag, statusAxis, moduleStatusCode};
      end else if (araddr == `OFS_OPERAND) begin
         rdWord = loaded;
      end else if (araddr == `OFS_RESULT) begin
         rdWord = result_q;
      end else if (araddr == `OFS_ARITH_HI) begin
         rdWord = arithHi_q;
      end else if (araddr == `OFS_ARITH_LO) begin
         rdWord = arithLo_q;
      end else if (araddr == `OFS_DIVISOR) begin
         rdWord = divisor_q;
      end else begin
         rdWord = 32'h0000_0000;
         rdHit = 1'b0;
      end
   end
endmodule // logic_error_reporter

// ### sim/logic_error_reporter_monitor.sv
/* Checker of the error reporter: codes, stops and flags against their causes.
   Assumes a bind onto the reporter, one clock and srst active high. */
`timescale 1ns/10ps
module logic_error_reporter_monitor
   import logic_error_pkg::*;
#(
   parameter int AxisCount = 4
) (
   input wire logic clk,
   input wire logic srst,
   input wire logic awvalid,
   input wire logic wvalid,
   input wire logic eventValid,
   input wire event_t eventKind,
   input wire logic [4:0] preprocIndex,
   input wire logic [1:0] stopAxis,
   input wire logic sweepStart,
   input wire logic haltRequest,
   input wire logic [AxisCount-1:0] axisFault,
   input wire logic [15:0] moduleStatusCode,
   input wire logic statusAxisValid,
   input wire logic [1:0] statusAxis,
   input wire logic moduleFastStop,
   input wire logic [AxisCount-1:0] axisFastStop,
   input wire logic logicHalted,
   input wire logic firstSweepFlag
);
   // ---------------------------------------------------------------------
   // Checks
   // ---------------------------------------------------------------------
   logic quiet;
   // Bus writes can start arithmetic of higher priority, so those cycles are left out.
   assign quiet = eventValid && !haltRequest && !awvalid && !wvalid;
   default clocking @(posedge clk); endclocking
   default disable iff (srst);
   a_halt_code: assert property (haltRequest
      |=> moduleStatusCode == 16'h0091 && moduleFastStop && logicHalted) else $error("halt not reported");
   a_stop_kinds: assert property (quiet && eventKind inside {EV_HALT, EV_TIME_LIMIT}
      |=> moduleFastStop) else $error("no fast stop");
   a_status_only: assert property (quiet && eventKind == EV_TIME_WARN
      |=> moduleStatusCode == 16'h0097 && moduleFastStop == $past(moduleFastStop)) else $error("warning wrong");
   a_config_code: assert property (quiet && eventKind inside {EV_DOUT_CFG, EV_CTLBIT_CFG}
      |=> moduleStatusCode == (($past(eventKind) == EV_DOUT_CFG) ? 16'h000A : 16'h000B)) else $error("config code");
   a_preproc_code: assert property (quiet && eventKind == EV_PREPROC && preprocIndex <= 5'h18
      && preprocIndex != 5'h0F |=> moduleStatusCode == 16'hF0A0 + {11'h000, $past(preprocIndex)})
      else $error("preprocess code");
   a_logic_stop: assert property (quiet && eventKind == EV_LOGIC_STOP
      |=> moduleStatusCode == 16'h009A && statusAxisValid && statusAxis == $past(stopAxis)
      && axisFastStop[$past(stopAxis)]) else $error("axis stop wrong");
   a_first_sweep: assert property (firstSweepFlag && sweepStart |=> !firstSweepFlag)
      else $error("first sweep flag held");
   a_axis_fault: assert property (|axisFault
      |=> (axisFastStop & $past(axisFault)) == $past(axisFault)) else $error("axis fault lost");
endmodule // logic_error_reporter_monitor

// ### sim/engine_model.sv
/* Engine side model: event, halt and sweep strobes of one cycle each.
   Assumes the reporter samples them on the rising clock edge. */
`timescale 1ns/10ps
module engine_model
   import logic_error_pkg::*;
(
   input wire logic clk,
   output logic eventValid,
   output event_t eventKind,
   output logic [4:0] preprocIndex,
   output logic [1:0] stopAxis,
   output logic sweepStart,
   output logic haltRequest
);
   // ---------------------------------------------------------------------
   // Strobes
   // ---------------------------------------------------------------------
   initial begin
      eventKind = EV_NONE;
      {eventValid, preprocIndex, stopAxis, sweepStart, haltRequest} = '0;
   end
   task fire(input event_t k, input logic [4:0] i, input logic [1:0] a);
      @(posedge clk);
      eventValid <= 1'h1;
      eventKind <= k;
      preprocIndex <= i;
      stopAxis <= a;
      @(posedge clk);
      eventValid <= 1'h0;
      #1;
   endtask
   task tick(input logic h, input logic s);
      @(posedge clk);
      haltRequest <= h;
      sweepStart <= s;
      @(posedge clk);
      haltRequest <= 1'h0;
      sweepStart <= 1'h0;
      #1;
   endtask
endmodule // engine_model

// ### sim/logic_error_reporter_test.sv
/* Self-checking bench of the error reporter, registers reached over AXI4-Lite.
   Assumes the engine model and the checker bound at the foot of this file. */
`timescale 1ns/10ps
module logic_error_reporter_test
   import logic_error_pkg::*;
;
   // ---------------------------------------------------------------------
   // Bench
   // ---------------------------------------------------------------------
   logic clk, srst, awvalid, wvalid, bready, arvalid, rready, awready, wready, bvalid, arready, rvalid, overflowFlag;
   logic eventValid, sweepStart, haltRequest, statusAxisValid, moduleFastStop, logicHalted, firstSweepFlag;
   logic [4:0] awaddr, araddr, preprocIndex;
   logic [31:0] wdata, rdata, analogCommandWord, d, ctl;
   logic [3:0] wstrb, axisFault, axisFastStop;
   logic [1:0] bresp, rresp, resp, statusAxis, stopAxis;
   logic [15:0] moduleStatusCode;
   event_t eventKind;
   int mismatches, tests_run, cycles;
   event_t evK[8] = '{EV_DOUT_CFG, EV_CTLBIT_CFG, EV_HALT, EV_TIME_LIMIT, EV_TIME_WARN, EV_FIRST_SWEEP,
      EV_BAD_PROGRAM, EV_LOGIC_STOP};
   logic [15:0] evC[8] = '{16'h000A, 16'h000B, 16'h0091, 16'h0092, 16'h0097, 16'h0098, 16'h0099, 16'h009A};
   logic_error_reporter uut (.clk, .srst, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready, .bresp,
      .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready, .eventValid, .eventKind,
      .preprocIndex, .stopAxis, .sweepStart, .haltRequest, .axisFault, .moduleStatusCode, .statusAxisValid,
      .statusAxis, .moduleFastStop, .axisFastStop, .logicHalted, .firstSweepFlag, .overflowFlag, .analogCommandWord);
   engine_model eng (.clk, .eventValid, .eventKind, .preprocIndex, .stopAxis, .sweepStart, .haltRequest);
   initial begin
      clk = 1'h0;
      forever #2.5 clk = ~clk;
   end
   task chk(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         mismatches++;
         $display("BAD %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task report_and_stop;
      $display("Compared %0d, mismatched %0d", tests_run, mismatches);
      if (mismatches == 0 && tests_run > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask
   task wr(input logic [4:0] a, input logic [31:0] v, input logic [3:0] s);
      logic ga, gw, gb;
      @(posedge clk);
      {awaddr, wdata, wstrb} <= {a, v, s};
      {awvalid, wvalid, bready} <= 3'h7;
      do begin
         @(negedge clk);
         {ga, gw, gb, resp} = {awready, wready, bvalid, bresp};
         @(posedge clk);
         if (ga) awvalid <= 1'h0;
         if (gw) wvalid <= 1'h0;
      end while (!gb);
      bready <= 1'h0;
      #1;
   endtask
   task rd(input logic [4:0] a);
      logic ga, gr;
      @(posedge clk);
      araddr <= a;
      {arvalid, rready} <= 2'h3;
      do begin
         @(negedge clk);
         {ga, gr, d} = {arready, rvalid, rdata};
         @(posedge clk);
         if (ga) arvalid <= 1'h0;
      end while (!gr);
      rready <= 1'h0;
      #1;
   endtask
   task clr;
      wr(5'h00, ctl | 32'h4, 4'hF);
      wr(5'h00, ctl, 4'hF);
   endtask
   task op(input logic [31:0] hi, lo, b, input arith_op_t o, input logic [31:0] r, input logic [15:0] c,
      input logic [1:0] f);
      wr(5'h14, hi, 4'hF);
      wr(5'h18, lo, 4'hF);
      wr(5'h1C, b, 4'hF);
      clr;
      wr(5'h1C, {o, b[29:0]}, 4'h8);
      rd(5'h10);
      if (c == 16'h0000) chk(d, r);
      else chk(moduleStatusCode, c);
      chk({moduleFastStop, overflowFlag}, f);
   endtask
   task ld(input logic [5:0] w, input logic s, input logic [31:0] raw, exp);
      wr(5'h00, {16'h0000, 1'h0, s, w, 8'h00}, 4'hF);
      wr(5'h0C, raw, 4'hF);
      rd(5'h0C);
      chk(d, exp);
   endtask
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         mismatches++;
         report_and_stop;
      end
   end
   initial begin
      {srst, awvalid, wvalid, bready, arvalid, rready} = 6'h20;
      {awaddr, araddr, wdata, wstrb, axisFault, ctl} = '0;
      repeat (3) @(posedge clk);
      srst <= 1'h0;
      #1;
      chk({moduleStatusCode, moduleFastStop, logicHalted, firstSweepFlag, overflowFlag}, 32'h0);
      for (int i = 0; i < 8; i++) begin
         clr;
         eng.fire(evK[i], 5'h00, 2'h2);
         chk(moduleStatusCode, evC[i]);
         chk({moduleFastStop, statusAxisValid, axisFastStop}, {i inside {2, 3}, i == 7, 4'(i == 7) << 2});
      end
      rd(5'h08);
      chk(d[18:0], {1'h0, 2'h2, 16'h009A});
      $display("Test events finished");
      for (int i = 0; i < 26; i++) begin
         eng.fire(EV_PREPROC, i[4:0], 2'h0);
         chk(moduleStatusCode, (i == 15) ? 32'hF0AE : (i == 25) ? 32'hF0B8 : 32'hF0A0 + i);
      end
      clr;
      eng.tick(1'h1, 1'h0);
      chk({moduleStatusCode, moduleFastStop, logicHalted}, {16'h0091, 2'h3});
      @(posedge clk);
      axisFault <= 4'h8;
      @(posedge clk);
      axisFault <= 4'h0;
      #1;
      chk(axisFastStop[3], 1'h1);
      $display("Test preprocess and halt finished");
      op(32'h0, 32'h7FFFFFFF, 32'h1, OP_ADD, 32'h0, 16'h0095, 2'h1);
      ctl = 32'h3;
      wr(5'h00, ctl, 4'hF);
      eng.tick(1'h0, 1'h1);
      chk({firstSweepFlag, overflowFlag}, 2'h2);
      eng.tick(1'h0, 1'h1);
      chk(firstSweepFlag, 1'h0);
      ctl = 32'h0;
      op(32'h0, 32'h80000000, 32'h1, OP_SUB, 32'h0, 16'h0095, 2'h1);
      wr(5'h00, 32'h10, 4'hF);
      chk(overflowFlag, 1'h0);
      op(32'h0, 32'h80000000, 32'h0, OP_ABS, 32'h0, 16'h0096, 2'h1);
      op(32'h0, 32'hA, 32'h0, OP_DIV, 32'h0, 16'h0093, 2'h2);
      op(32'h1, 32'h0, 32'h1, OP_DIV, 32'h0, 16'h0094, 2'h2);
      op(32'hFFFFFFFF, 32'hFFFFFF9C, 32'h7, OP_DIV, 32'hFFFFFFF2, 16'h0000, 2'h0);
      $display("Test arithmetic finished");
      ld(6'h10, 1'h1, 32'h00018234, 32'hFFFF8234);
      ld(6'h10, 1'h0, 32'h00018234, 32'h00008234);
      ld(6'h01, 1'h0, 32'h00000003, 32'h00000001);
      wr(5'h00, 32'h0000A000, 4'hF);
      wr(5'h0C, 32'h00002710, 4'hF);
      chk(analogCommandWord, 32'h00002710);
      wr(5'h0C, 32'h00002711, 4'hF);
      chk(analogCommandWord, 32'h00002710);
      chk(moduleStatusCode, 32'h009B);
      wr(5'h04, 32'h1, 4'hF);
      chk(resp, 2'h2);
      $display("Test operands and bus finished");
      report_and_stop;
   end
endmodule // logic_error_reporter_test
bind logic_error_reporter logic_error_reporter_monitor #(.AxisCount(AxisCount)) mon (.clk, .srst, .awvalid, .wvalid,
   .eventValid, .eventKind, .preprocIndex, .stopAxis, .sweepStart, .haltRequest, .axisFault, .moduleStatusCode,
   .statusAxisValid, .statusAxis, .moduleFastStop, .axisFastStop, .logicHalted, .firstSweepFlag);
